/* hw/shpf_pkg.sv */
// shared constants for the serial host port framer
package shpf_pkg;
    localparam int unsigned CLK_HZ = 10_000_000;
    localparam int unsigned OVS = 16;
    // baud select codes
    localparam logic [2:0] BAUD_300  = 3'h0;
    localparam logic [2:0] BAUD_600  = 3'h1;
    localparam logic [2:0] BAUD_1200 = 3'h2;
    localparam logic [2:0] BAUD_2400 = 3'h3;
    localparam logic [2:0] BAUD_4800 = 3'h4;
    localparam logic [2:0] BAUD_9600 = 3'h5;
    localparam logic [2:0] BAUD_RST  = BAUD_9600;
    // oversample tick divisors: clk / (baud * 16), rounded down
    localparam logic [11:0] DIV_300  = 12'(CLK_HZ / (300 * OVS));
    localparam logic [11:0] DIV_600  = 12'(CLK_HZ / (600 * OVS));
    localparam logic [11:0] DIV_1200 = 12'(CLK_HZ / (1200 * OVS));
    localparam logic [11:0] DIV_2400 = 12'(CLK_HZ / (2400 * OVS));
    localparam logic [11:0] DIV_4800 = 12'(CLK_HZ / (4800 * OVS));
    localparam logic [11:0] DIV_9600 = 12'(CLK_HZ / (9600 * OVS));
    // character formats
    localparam logic [1:0] FMT_N8 = 2'h0;
    localparam logic [1:0] FMT_E7 = 2'h1;
    localparam logic [1:0] FMT_O7 = 2'h2;
    localparam logic [1:0] FMT_RST = FMT_N8;
    localparam int unsigned STOP_BITS = 2;
    localparam int unsigned FIFO_DEPTH = 16;
    localparam int unsigned FIFO_AW = 4;
    // register byte offsets
    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_TXDATA = 8'h08;
    localparam logic [7:0] OFS_RXDATA = 8'h0c;
    // ctrl fields
    localparam int unsigned CTRL_BAUD_LSB = 0;
    localparam int unsigned CTRL_FMT_LSB  = 4;
    localparam int unsigned CTRL_DTR_BIT  = 8;
    localparam logic [31:0] CTRL_RST = 32'h0000_0005;
    // status fields
    localparam int unsigned ST_RXAV  = 0;
    localparam int unsigned ST_TXFUL = 1;
    localparam int unsigned ST_TXBSY = 2;
    localparam int unsigned ST_FERR  = 3;
    localparam int unsigned ST_PERR  = 4;
    localparam int unsigned ST_OVR   = 5;
    localparam int unsigned ST_DSR   = 6;
    localparam int unsigned ST_RXBSY = 7;
    typedef enum logic [2:0] {
        SHPF_IDLE   = 3'b000,
        SHPF_START  = 3'b001,
        SHPF_DATA   = 3'b010,
        SHPF_PARITY = 3'b011,
        SHPF_STOP   = 3'b100
    } shpf_state_t;
endpackage : shpf_pkg

/* hw/shpf_fifo.sv */
// synchronous valid/ready fifo in flip-flops
`timescale 1ns/1ns
module shpf_fifo #(
    parameter int unsigned WIDTH = 8,
    parameter int unsigned DEPTH = 16,
    parameter int unsigned AW    = 4
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             sys_rst,
    // fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wr_q;
    logic [AW-1:0]    rd_q;
    logic [AW:0]      cnt_q;
    logic             push;
    logic             pop;

    assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    assign out_data  = mem_q[rd_q];

    always_ff @(posedge clk) begin
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wr_q <= wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= rd_q + 1'b1;
            end
            if (push && !pop) begin
                cnt_q <= cnt_q + 1'b1;
            end else if (pop && !push) begin
                cnt_q <= cnt_q - 1'b1;
            end
        end
    end
endmodule : shpf_fifo

/* hw/shpf_top.sv */
// serial host port framer: apb registers, dte transmitter and receiver
//
// Local design decisions: the APB register port and the placing of the registers.
`timescale 1ns/1ns
module shpf_top (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        sys_rst,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // serial pins
    output logic             txd,
    input  wire logic        rxd,
    output logic             dtr,
    input  wire logic        dsr
);
    logic [31:0] ctrl_q;
    logic [2:0]  baud_act_q;
    logic [1:0]  fmt_act_q;
    logic [11:0] div_val;
    logic [11:0] div_q;
    logic        tick;
    logic        apb_wr;
    logic        apb_rd;
    logic        tf_in_valid;
    logic        tf_in_ready;
    logic        tf_out_valid;
    logic        tf_out_ready;
    logic [7:0]  tf_out_data;
    logic        tx_idle;
    logic        rx_idle;
    logic        ferr_q;
    logic        perr_q;
    logic        ovr_q;
    logic        rx_av_q;
    logic [7:0]  rx_buf_q;
    logic        rx_set;
    logic        ferr_set;
    logic        perr_set;
    logic        ovr_set;
    logic        rx_clr;
    logic        err_clr;

    assign apb_wr  = psel && penable && pwrite;
    assign apb_rd  = psel && penable && !pwrite;
    assign pready  = 1'b1;
    assign pslverr = 1'b0;
    assign tf_in_valid = apb_wr && (paddr == shpf_pkg::OFS_TXDATA);
    assign rx_clr  = apb_rd && (paddr == shpf_pkg::OFS_RXDATA);
    assign err_clr = apb_wr && (paddr == shpf_pkg::OFS_STATUS);

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ctrl_q <= shpf_pkg::CTRL_RST;
        end else if (apb_wr && paddr == shpf_pkg::OFS_CTRL) begin
            ctrl_q <= {23'h0, pwdata[8:0]};
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            baud_act_q <= shpf_pkg::BAUD_RST;
            fmt_act_q  <= shpf_pkg::FMT_RST;
        end else if (tx_idle && rx_idle) begin
            baud_act_q <= ctrl_q[shpf_pkg::CTRL_BAUD_LSB +: 3];
            fmt_act_q  <= ctrl_q[shpf_pkg::CTRL_FMT_LSB +: 2];
        end
    end

    always_comb begin
        unique case (baud_act_q)
            shpf_pkg::BAUD_300:  div_val = shpf_pkg::DIV_300;
            shpf_pkg::BAUD_600:  div_val = shpf_pkg::DIV_600;
            shpf_pkg::BAUD_1200: div_val = shpf_pkg::DIV_1200;
            shpf_pkg::BAUD_2400: div_val = shpf_pkg::DIV_2400;
            shpf_pkg::BAUD_4800: div_val = shpf_pkg::DIV_4800;
            default:             div_val = shpf_pkg::DIV_9600;
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst || div_q >= div_val - 12'h1) begin
            div_q <= 12'h0;
        end else begin
            div_q <= div_q + 12'h1;
        end
    end
    assign tick = (div_q >= div_val - 12'h1);

    // transmit path through the fifo
    shpf_fifo #(
        .WIDTH (8),
        .DEPTH (shpf_pkg::FIFO_DEPTH),
        .AW    (shpf_pkg::FIFO_AW)
    ) u_txfifo (
        .clk       (clk),
        .sys_rst   (sys_rst),
        .in_valid  (tf_in_valid),
        .in_ready  (tf_in_ready),
        .in_data   (pwdata[7:0]),
        .out_valid (tf_out_valid),
        .out_ready (tf_out_ready),
        .out_data  (tf_out_data)
    );

    // ---- transmitter
    shpf_pkg::shpf_state_t tx_st_q;
    logic [3:0] tx_ph_q;
    logic [3:0] tx_bit_q;
    logic [7:0] tx_sh_q;
    logic       tx_par_q;
    logic       txd_q;
    logic       tx_seven;
    logic       tx_bit_end;

    assign tx_seven   = (fmt_act_q != shpf_pkg::FMT_N8);
    assign tx_bit_end = tick && (tx_ph_q == 4'hf);
    assign tx_idle    = (tx_st_q == shpf_pkg::SHPF_IDLE);
    assign tf_out_ready = tx_idle && dsr && tick;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            tx_st_q  <= shpf_pkg::SHPF_IDLE;
            tx_ph_q  <= 4'h0;
            tx_bit_q <= 4'h0;
            tx_sh_q  <= 8'h0;
            tx_par_q <= 1'b0;
            txd_q    <= 1'b1;
        end else begin
            if (tick && !tx_idle) begin
                tx_ph_q <= tx_ph_q + 4'h1;
            end
            unique case (tx_st_q)
                shpf_pkg::SHPF_IDLE: begin
                    txd_q <= 1'b1;
                    if (tf_out_valid && tf_out_ready) begin
                        tx_st_q  <= shpf_pkg::SHPF_START;
                        tx_sh_q  <= tf_out_data;
                        tx_par_q <= (fmt_act_q == shpf_pkg::FMT_O7);
                        tx_ph_q  <= 4'h0;
                        txd_q    <= 1'b0;
                    end
                end
                shpf_pkg::SHPF_START: begin
                    if (tx_bit_end) begin
                        tx_st_q  <= shpf_pkg::SHPF_DATA;
                        tx_bit_q <= 4'h0;
                        txd_q    <= tx_sh_q[0];
                        tx_par_q <= tx_par_q ^ tx_sh_q[0];
                        tx_sh_q  <= {1'b0, tx_sh_q[7:1]};
                    end
                end
                shpf_pkg::SHPF_DATA: begin
                    if (tx_bit_end) begin
                        tx_bit_q <= tx_bit_q + 4'h1;
                        if (tx_bit_q == (tx_seven ? 4'h6 : 4'h7)) begin
                            tx_bit_q <= 4'h0;
                            if (tx_seven) begin
                                tx_st_q <= shpf_pkg::SHPF_PARITY;
                                txd_q   <= tx_par_q;
                            end else begin
                                tx_st_q <= shpf_pkg::SHPF_STOP;
                                txd_q   <= 1'b1;
                            end
                        end else begin
                            txd_q    <= tx_sh_q[0];
                            tx_par_q <= tx_par_q ^ tx_sh_q[0];
                            tx_sh_q  <= {1'b0, tx_sh_q[7:1]};
                        end
                    end
                end
                shpf_pkg::SHPF_PARITY: begin
                    if (tx_bit_end) begin
                        tx_st_q <= shpf_pkg::SHPF_STOP;
                        txd_q   <= 1'b1;
                    end
                end
                shpf_pkg::SHPF_STOP: begin
                    if (tx_bit_end) begin
                        tx_bit_q <= tx_bit_q + 4'h1;
                        if (tx_bit_q == 4'(shpf_pkg::STOP_BITS - 1)) begin
                            tx_st_q <= shpf_pkg::SHPF_IDLE;
                        end
                    end
                end
                default: tx_st_q <= shpf_pkg::SHPF_IDLE;
            endcase
        end
    end
    assign txd = txd_q;
    assign dtr = ctrl_q[shpf_pkg::CTRL_DTR_BIT];

    // ---- receiver
    shpf_pkg::shpf_state_t rx_st_q;
    logic [3:0] rx_ph_q;
    logic [3:0] rx_bit_q;
    logic [7:0] rx_sh_q;
    logic       rx_par_q;
    logic       rx_pbad_q;
    logic       rx_mid;

    assign rx_idle = (rx_st_q == shpf_pkg::SHPF_IDLE);
    assign rx_mid  = tick && (rx_ph_q == 4'h7);
    assign rx_set   = rx_mid && (rx_st_q == shpf_pkg::SHPF_STOP) &&
                      (rx_bit_q == 4'(shpf_pkg::STOP_BITS - 1));
    assign ferr_set = rx_mid && (rx_st_q == shpf_pkg::SHPF_STOP) && !rxd;
    assign perr_set = rx_set && rx_pbad_q;
    assign ovr_set  = rx_set && rx_av_q && !rx_clr;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rx_st_q   <= shpf_pkg::SHPF_IDLE;
            rx_ph_q   <= 4'h0;
            rx_bit_q  <= 4'h0;
            rx_sh_q   <= 8'h0;
            rx_par_q  <= 1'b0;
            rx_pbad_q <= 1'b0;
        end else begin
            if (tick) begin
                rx_ph_q <= rx_ph_q + 4'h1;
            end
            unique case (rx_st_q)
                shpf_pkg::SHPF_IDLE: begin
                    if (tick && !rxd && dtr) begin
                        rx_st_q   <= shpf_pkg::SHPF_START;
                        rx_ph_q   <= 4'h1;
                        rx_par_q  <= (fmt_act_q == shpf_pkg::FMT_O7);
                        rx_pbad_q <= 1'b0;
                        rx_bit_q  <= 4'h0;
                        rx_sh_q   <= 8'h0;
                    end
                end
                shpf_pkg::SHPF_START: begin
                    // glitch filter: start must hold to mid-bit
                    if (rx_mid) begin
                        rx_st_q <= rxd ? shpf_pkg::SHPF_IDLE
                                       : shpf_pkg::SHPF_DATA;
                    end
                end
                shpf_pkg::SHPF_DATA: begin
                    if (rx_mid) begin
                        rx_bit_q <= rx_bit_q + 4'h1;
                        rx_par_q <= rx_par_q ^ rxd;
                        if (fmt_act_q != shpf_pkg::FMT_N8) begin
                            rx_sh_q <= {1'b0, rxd, rx_sh_q[6:1]};
                        end else begin
                            rx_sh_q <= {rxd, rx_sh_q[7:1]};
                        end
                        if (rx_bit_q == ((fmt_act_q != shpf_pkg::FMT_N8)
                                         ? 4'h6 : 4'h7)) begin
                            rx_bit_q <= 4'h0;
                            rx_st_q  <= (fmt_act_q != shpf_pkg::FMT_N8)
                                        ? shpf_pkg::SHPF_PARITY
                                        : shpf_pkg::SHPF_STOP;
                        end
                    end
                end
                shpf_pkg::SHPF_PARITY: begin
                    if (rx_mid) begin
                        rx_pbad_q <= rx_par_q ^ rxd;
                        rx_st_q   <= shpf_pkg::SHPF_STOP;
                    end
                end
                shpf_pkg::SHPF_STOP: begin
                    if (rx_mid) begin
                        rx_bit_q <= rx_bit_q + 4'h1;
                        if (rx_bit_q == 4'(shpf_pkg::STOP_BITS - 1)) begin
                            rx_st_q <= shpf_pkg::SHPF_IDLE;
                        end
                    end
                end
                default: rx_st_q <= shpf_pkg::SHPF_IDLE;
            endcase
        end
    end

    // received character and sticky flags; set wins over clear
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rx_buf_q <= 8'h0;
        end else if (rx_set) begin
            rx_buf_q <= rx_sh_q;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rx_av_q <= 1'b0;
            ferr_q  <= 1'b0;
            perr_q  <= 1'b0;
            ovr_q   <= 1'b0;
        end else begin
            rx_av_q <= rx_set || (rx_av_q && !rx_clr);
            ferr_q  <= ferr_set ||
                       (ferr_q && !(err_clr && pwdata[shpf_pkg::ST_FERR]));
            perr_q  <= perr_set ||
                       (perr_q && !(err_clr && pwdata[shpf_pkg::ST_PERR]));
            ovr_q   <= ovr_set ||
                       (ovr_q && !(err_clr && pwdata[shpf_pkg::ST_OVR]));
        end
    end

    // read data registered at the setup phase
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            prdata <= 32'h0;
        end else if (psel && !penable) begin
            unique case (paddr)
                shpf_pkg::OFS_CTRL:   prdata <= ctrl_q;
                shpf_pkg::OFS_STATUS: prdata <= {24'h0, !rx_idle, dsr,
                    ovr_q, perr_q, ferr_q, !tx_idle || tf_out_valid,
                    !tf_in_ready, rx_av_q};
                shpf_pkg::OFS_RXDATA: prdata <= {24'h0, rx_buf_q};
                default:              prdata <= 32'h0;
            endcase
        end
    end
endmodule : shpf_top

/* dv/shpf_monitor.sv */
// pin level checks for the serial host port framer
`timescale 1ns/1ns
module shpf_monitor (
    // clock and reset
    input wire logic        clk,
    input wire logic        sys_rst,
    // apb slave
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // serial pins
    input wire logic        txd,
    input wire logic        rxd,
    input wire logic        dtr,
    input wire logic        dsr
);
    // above any high run inside a 300 baud frame
    localparam logic [19:0] LONG_IDLE = 20'h53020;
    logic [19:0] run_q;
    logic        txd_q;
    always_ff @(posedge clk) begin
        txd_q <= txd;
    end
    // saturates so a long idle line stays recognisable
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            run_q <= 20'hfffff;
        end else if (txd != txd_q) begin
            run_q <= 20'h00000;
        end else if (run_q != 20'hfffff) begin
            run_q <= run_q + 20'h00001;
        end
    end
    sequence ctrl_wr;
        psel && penable && pwrite && paddr == shpf_pkg::OFS_CTRL;
    endsequence
    sequence dsr_off;
        !dsr [*4];
    endsequence
    zero_wait_a: assert property (@(posedge clk) disable iff (sys_rst)
        psel && penable |-> pready) else $error("pready low in access");
    no_error_a: assert property (@(posedge clk) disable iff (sys_rst)
        psel && penable |-> !pslverr) else $error("pslverr raised");
    dtr_load_a: assert property (@(posedge clk) disable iff (sys_rst)
        ctrl_wr |=> dtr == $past(pwdata[8])) else $error("dtr not loaded");
    dtr_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
        $changed(dtr) |-> $past(sys_rst) || $past(psel && penable
        && pwrite && paddr == shpf_pkg::OFS_CTRL)) else $error("dtr moved");
    reset_idle_a: assert property (@(posedge clk)
        sys_rst |=> txd && !dtr) else $error("pins not idle in reset");
    bit_len_a: assert property (@(posedge clk) disable iff (sys_rst)
        txd != txd_q |-> run_q >= 20'd1000) else $error("txd bit short");
    dsr_gate_a: assert property (@(posedge clk) disable iff (sys_rst)
        dsr_off ##0 (txd && run_q >= LONG_IDLE) |=> txd)
        else $error("frame started without dsr");
    rdata_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
        !psel |=> $stable(prdata)) else $error("prdata moved while idle");
endmodule : shpf_monitor

/* dv/shpf_host_model.sv */
// behavioural host serial port facing the framer pins
`timescale 1ns/1ns
module shpf_host_model (
    // clock
    input wire logic clk,
    // serial pins seen from the host
    input wire logic txd,
    output logic     rxd,
    output logic     dsr
);
    // host runs the port's 9600 baud bit time
    int          bit_clks = shpf_pkg::DIV_9600 * shpf_pkg::OVS;
    logic [11:0] got_q[$];
    // dsr held low until the bench says ready
    initial begin
        rxd = 1'b1;
        dsr = 1'b0;
    end
    // eleven bits, start through second stop
    always begin : rx_proc
        logic [11:0] f;
        f = 12'h000;
        @(negedge txd);
        repeat (bit_clks / 2) @(posedge clk);
        for (int i = 0; i < 11; i++) begin
            f[i] = txd;
            if (i < 10) repeat (bit_clks) @(posedge clk);
        end
        got_q.push_back(f);
    end
    // remote-mode command is only characters at this level
    // one start, two stops, same format
    task send(input logic [11:0] f);
        for (int i = 0; i < 11; i++) begin
            rxd <= f[i];
            repeat (bit_clks) @(posedge clk);
        end
    endtask : send
endmodule : shpf_host_model

/* dv/testbench.sv */
// self-checking bench for the serial host port framer
`timescale 1ns/1ns
module testbench;
    logic        clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready, pslverr, txd, rxd, dtr, dsr;
    int          bad_count = 0;
    int          checks = 0;
    int          seed = 27131;
    int          n;
    logic [31:0] rd, w;
    logic [7:0]  c;
    logic [11:0] exp_q[$];
    always #50 clk = ~clk;
    shpf_top dut (.clk(clk), .sys_rst(sys_rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .txd(txd),
        .rxd(rxd), .dtr(dtr), .dsr(dsr));
    shpf_host_model host (.clk(clk), .txd(txd), .rxd(rxd), .dsr(dsr));
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task conclude;
        $display("checks=%0d bad_count=%0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : conclude
    // request held until pready is seen at a rising edge
    task apb(input logic [7:0] a, input logic wr, input logic [31:0] d,
             output logic [31:0] r);
        int k;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= wr;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        for (k = 0; k < 50; k++) begin
            @(posedge clk);
            if (pready === 1'b1) break;
        end
        if (k == 50) begin
            bad_count++;
            conclude();
        end
        r = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // reference frame, lsb first, parity only in 7-bit formats
    function automatic logic [11:0] mk(logic [7:0] ch, int fmt,
                                       bit bad_stop, bit bad_par);
        logic [11:0] f;
        f = 12'h000;
        for (int i = 0; i < 8; i++) f[1+i] = ch[i];
        if (fmt != 0) f[8] = ^ch[6:0] ^ (fmt == 2) ^ bad_par;
        f[9] = ~bad_stop;
        f[10] = 1'b1;
        return f;
    endfunction : mk
    task drain_host(input int cnt);
        for (int k = 0; k < 300000 && host.got_q.size() < cnt; k++)
            @(posedge clk);
        if (host.got_q.size() < cnt) begin
            bad_count++;
            conclude();
        end
        for (int k = 0; k < cnt; k++) chk(host.got_q.pop_front(),
            exp_q.pop_front());
    endtask : drain_host
    initial begin
        repeat (6) @(posedge clk);
        sys_rst <= 1'b0;
        apb(shpf_pkg::OFS_CTRL, 1'b0, 32'h0, rd);
        chk(rd, shpf_pkg::CTRL_RST);
        apb(shpf_pkg::OFS_STATUS, 1'b0, 32'h0, rd);
        chk(rd & 32'hff, 32'h0);
        chk({txd, dtr}, 2'b10);
        apb(8'h10, 1'b1, $random(seed), rd);
        apb(8'h10, 1'b0, 32'h0, rd);
        chk(rd, 32'h0);
        $display("test reset done");
        // every baud code with a random format and dtr
        for (int b = 0; b < 6; b++) begin
            w = b | ({$random(seed)} % 3) << 4 | ($random(seed) & 1) << 8;
            apb(shpf_pkg::OFS_CTRL, 1'b1, w, rd);
            apb(shpf_pkg::OFS_CTRL, 1'b0, 32'h0, rd);
            chk(rd & 32'h137, w);
            chk(dtr, w[8]);
        end
        $display("test ctrl done");
        apb(shpf_pkg::OFS_CTRL, 1'b1, 32'h105, rd);
        // dsr low: fifo fills, seventeenth word refused
        for (int i = 0; i < 17; i++) begin
            c = $random(seed);
            apb(shpf_pkg::OFS_TXDATA, 1'b1, {24'h0, c}, rd);
            if (i < 16) exp_q.push_back(mk(c, 0, 0, 0));
            apb(shpf_pkg::OFS_STATUS, 1'b0, 32'h0, rd);
            chk(rd[shpf_pkg::ST_TXFUL], i >= 15);
        end
        chk(host.got_q.size(), 0);
        // mid-run reset empties the fifo; draining sixteen costs 180k clocks
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        exp_q.delete();
        apb(shpf_pkg::OFS_STATUS, 1'b0, 32'h0, rd);
        chk(rd & 32'hff, 32'h0);
        apb(shpf_pkg::OFS_CTRL, 1'b1, 32'h105, rd);
        for (int i = 0; i < 5; i++) begin
            c = $random(seed);
            apb(shpf_pkg::OFS_TXDATA, 1'b1, {24'h0, c}, rd);
            exp_q.push_back(mk(c, 0, 0, 0));
        end
        host.dsr <= 1'b1;
        $display("test fill done");
        c = $random(seed);
        host.send(mk(c, 0, 0, 0));
        apb(shpf_pkg::OFS_STATUS, 1'b0, 32'h0, rd);
        chk(rd[shpf_pkg::ST_RXAV], 1'b1);
        chk(rd[shpf_pkg::ST_DSR], 1'b1);
        apb(shpf_pkg::OFS_RXDATA, 1'b0, 32'h0, rd);
        chk(rd & 32'hff, c);
        host.send(mk($random(seed), 0, 1, 0));
        apb(shpf_pkg::OFS_STATUS, 1'b0, 32'h0, rd);
        chk(rd[shpf_pkg::ST_FERR], 1'b1);
        apb(shpf_pkg::OFS_STATUS, 1'b1, 32'h8, rd);
        apb(shpf_pkg::OFS_STATUS, 1'b0, 32'h0, rd);
        chk(rd[shpf_pkg::ST_FERR], 1'b0);
        host.send(mk($random(seed), 0, 0, 0));
        c = $random(seed);
        host.send(mk(c, 0, 0, 0));
        apb(shpf_pkg::OFS_STATUS, 1'b0, 32'h0, rd);
        chk(rd[shpf_pkg::ST_OVR], 1'b1);
        apb(shpf_pkg::OFS_RXDATA, 1'b0, 32'h0, rd);
        chk(rd & 32'hff, c);
        apb(shpf_pkg::OFS_STATUS, 1'b1, 32'h20, rd);
        $display("test receive done");
        // far side stalls: at most the frame in flight completes
        host.dsr <= 1'b0;
        n = host.got_q.size();
        repeat (12000) @(posedge clk);
        chk(host.got_q.size() <= n + 1, 1);
        host.dsr <= 1'b1;
        drain_host(5);
        $display("test drain done");
        repeat (1040) @(posedge clk);
        // seven-bit formats, even one with a parity fault
        for (int f = 1; f < 3; f++) begin
            apb(shpf_pkg::OFS_CTRL, 1'b1, 32'h105 | f << 4, rd);
            c = $random(seed);
            apb(shpf_pkg::OFS_TXDATA, 1'b1, {24'h0, c}, rd);
            exp_q.push_back(mk(c & 8'h7f, f, 0, 0));
            c = $random(seed);
            host.send(mk(c, f, 0, f == 1));
            apb(shpf_pkg::OFS_STATUS, 1'b0, 32'h0, rd);
            chk(rd[shpf_pkg::ST_PERR], f == 1);
            apb(shpf_pkg::OFS_RXDATA, 1'b0, 32'h0, rd);
            chk(rd & 32'hff, c & 8'h7f);
            apb(shpf_pkg::OFS_STATUS, 1'b1, 32'h10, rd);
            drain_host(1);
            repeat (1040) @(posedge clk);
        end
        $display("test formats done");
        conclude();
    end
endmodule : testbench
bind shpf_top shpf_monitor mon (.clk(clk), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .txd(txd),
    .rxd(rxd), .dtr(dtr), .dsr(dsr));
